// *** hw/system_timer.sv ***
// system timer: seconds counter, interval timer, watchdog and interrupt masking
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "system_timer_map.svh"
module system_timer import system_timer_pkg::*; #(
   parameter int SECOND_DIV = `SECOND_CYCLES,
   parameter int INTERVAL_DIV = `INTERVAL_PRESCALE
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // timer events
   output logic timer_irq_out,
   output logic watchdog_reset_out
);
   // one register image of all timer state
   typedef struct packed {
      irq_vec_t status;
      irq_vec_t mask;
      logic [15:0] interval_period;
      logic [15:0] interval_count;
      logic [15:0] watchdog_reload;
      logic [15:0] watchdog_count;
      logic watchdog_enable;
      logic watchdog_reset;
      logic [31:0] seconds_counter;
      logic [31:0] alarm;
      logic [31:0] rdata;
   } timer_state_t;
   timer_state_t state_q;
   timer_state_t state_d;
   logic second_tick;
   logic interval_prescale_tick;

   // both prescalers need at least two cycles to form a one-cycle pulse
   if (SECOND_DIV < 2) begin : g_second_div_check
      $error("SECOND_DIV must be at least 2");
   end
   if (INTERVAL_DIV < 2) begin : g_interval_div_check
      $error("INTERVAL_DIV must be at least 2");
   end

   // next value of a down counter; callers test for the end value first
   function automatic logic [15:0] count_down(input logic [15:0] value);
      return value - 16'h0001;
   endfunction

   // the seconds counter wraps after the full 32-bit range
   function automatic logic [31:0] next_second(input logic [31:0] value);
      return value + 32'h00000001;
   endfunction

   // a one in the clear word masks its source, a zero keeps the old mask
   function automatic logic mask_after_clear(input logic current, input logic clear);
      return current & ~clear;
   endfunction

   // a four-bit flag vector as a register word, upper bits read zero
   function automatic logic [31:0] flags_word(input irq_vec_t flags);
      return {28'h0000000, flags};
   endfunction

   // restart needs the key in the upper half of the word
   function automatic logic restart_request(input logic [31:0] data);
      return data[`BIT_WD_RESTART] && (data[31:16] == `CONTROL_KEY);
   endfunction

   // a 32-bit prescaler holds a one-second count for clocks up to about four gigahertz
   localparam int DIV_WIDTH = 32;

   // one-second enable for the seconds counter
   tick_divider #(.WIDTH(DIV_WIDTH)) second_div (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .enable_in(1'b1),
      .div_in(DIV_WIDTH'(SECOND_DIV)),
      .tick_out(second_tick)
   );

   // slow time base for interval timer and watchdog
   tick_divider #(.WIDTH(DIV_WIDTH)) interval_div (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .enable_in(1'b1),
      .div_in(DIV_WIDTH'(INTERVAL_DIV)),
      .tick_out(interval_prescale_tick)
   );

   always_comb begin
      irq_vec_t ev;
      ev = '0;
      state_d = state_q;
      state_d.rdata = '0;
      state_d.watchdog_reset = 1'b0;

      // seconds counter and alarm
      if (second_tick) begin
         state_d.seconds_counter = next_second(state_q.seconds_counter);
         ev[`BIT_SECONDS] = 1'b1;
         // the alarm fires on the second the counter reaches it
         if (next_second(state_q.seconds_counter) == state_q.alarm) begin
            ev[`BIT_ALARM] = 1'b1;
         end
      end

      // interval timer reloads at the programmed period
      if (interval_prescale_tick) begin
         // a period of zero or one gives an event on every prescaled tick
         if (state_q.interval_count <= 16'h0001) begin
            state_d.interval_count = state_q.interval_period;
            ev[`BIT_INTERVAL] = 1'b1;
         end else begin
            state_d.interval_count = count_down(state_q.interval_count);
         end
      end

      // watchdog counts down unless restarted by software
      if (state_q.watchdog_enable && interval_prescale_tick) begin
         if (state_q.watchdog_count == 16'h0000) begin
            ev[`BIT_WATCHDOG] = 1'b1;
            state_d.watchdog_reset = 1'b1;
            state_d.watchdog_count = state_q.watchdog_reload;
         end else begin
            state_d.watchdog_count = count_down(state_q.watchdog_count);
         end
      end

      // register writes
      if (wr_in) begin
         case (addr_in)
            `OFS_CONTROL: begin
               // keyed so stray writes cannot keep a hung system alive
               if (restart_request(wdata_in)) begin
                  state_d.watchdog_count = state_q.watchdog_reload;
               end
            end
            `OFS_INTERVAL_MODE: begin
               // the count reloads too, so a new period starts at once
               state_d.interval_period = wdata_in[15:0];
               state_d.interval_count = wdata_in[15:0];
            end
            `OFS_WATCHDOG_MODE: begin
               // a mode write also restarts the count from the new reload
               state_d.watchdog_reload = wdata_in[15:0];
               state_d.watchdog_count = wdata_in[15:0];
               state_d.watchdog_enable = wdata_in[16];
            end
            `OFS_ALARM: begin
               state_d.alarm = wdata_in;
            end
            `OFS_MASK_SET: begin
               // the set word is the counterpart of the clear word
               state_d.mask = state_q.mask | wdata_in[3:0];
            end
            `OFS_MASK_CLEAR: begin
               // zeros leave the mask alone
               state_d.mask[`BIT_INTERVAL] = mask_after_clear(state_q.mask[`BIT_INTERVAL],
                  wdata_in[`BIT_INTERVAL]);
               state_d.mask[`BIT_WATCHDOG] = mask_after_clear(state_q.mask[`BIT_WATCHDOG],
                  wdata_in[`BIT_WATCHDOG]);
               state_d.mask[`BIT_SECONDS] = mask_after_clear(state_q.mask[`BIT_SECONDS],
                  wdata_in[`BIT_SECONDS]);
               state_d.mask[`BIT_ALARM] = mask_after_clear(state_q.mask[`BIT_ALARM],
                  wdata_in[`BIT_ALARM]);
            end
            // read-only and unmapped offsets ignore writes
            default: ;
         endcase
      end

      // register reads; status clears on read, new events win
      if (rd_in) begin
         case (addr_in)
            `OFS_INTERVAL_MODE: begin
               state_d.rdata = {16'h0000, state_q.interval_period};
            end
            `OFS_WATCHDOG_MODE: begin
               state_d.rdata = {15'h0000, state_q.watchdog_enable, state_q.watchdog_reload};
            end
            `OFS_ALARM: begin
               state_d.rdata = state_q.alarm;
            end
            `OFS_STATUS: begin
               state_d.rdata = flags_word(state_q.status);
               state_d.status = '0;
            end
            `OFS_MASK: begin
               state_d.rdata = flags_word(state_q.mask);
            end
            `OFS_SECONDS: begin
               state_d.rdata = state_q.seconds_counter;
            end
            // write-only and unmapped offsets read as zero
            default: state_d.rdata = '0;
         endcase
      end
      // an event in the cycle of a status read is kept for the next read
      state_d.status = state_d.status | ev;
   end

   // sync reset; both periods start at their slowest setting
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_q <= '0;
         state_q.mask <= `RST_MASK;
         state_q.interval_period <= `RST_INTERVAL_PERIOD;
         state_q.interval_count <= `RST_INTERVAL_PERIOD;
         state_q.watchdog_reload <= `RST_WATCHDOG_RELOAD;
         state_q.watchdog_count <= `RST_WATCHDOG_RELOAD;
      end else begin
         state_q <= state_d;
      end
   end

   // no flop after the mask gate, so a clear write drops the interrupt at once
   assign rdata_out = state_q.rdata;
   assign timer_irq_out = |(state_q.status & state_q.mask);
   assign watchdog_reset_out = state_q.watchdog_reset;
endmodule // system_timer

// *** hw/system_timer_map.svh ***
// register offsets, field positions, reset values and timing counts of the system timer
// Operation
// - disable bit 0 masks interval tick
// - disable bit 1 masks watchdog overflow; the code masks only the interrupt, watchdog_reset_out still pulses
// - disable bit 2 masks seconds increment
// - disable bit 3 masks alarm match
// - seconds counter advances each second, alarms
// - interval timer gives programmable periodic tick
// - watchdog overflow flags unserviced software
`ifndef SYSTEM_TIMER_MAP_SVH
`define SYSTEM_TIMER_MAP_SVH
`define OFS_CONTROL 8'h00
`define OFS_INTERVAL_MODE 8'h04
`define OFS_WATCHDOG_MODE 8'h08
`define OFS_ALARM 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK_SET 8'h14
`define OFS_MASK_CLEAR 8'h18
`define OFS_MASK 8'h1C
`define OFS_SECONDS 8'h20
`define BIT_INTERVAL 0
`define BIT_WATCHDOG 1
`define BIT_SECONDS 2
`define BIT_ALARM 3
`define BIT_WD_RESTART 0
`define CONTROL_KEY 16'hA5A5
`define RST_INTERVAL_PERIOD 16'hFFFF
`define RST_WATCHDOG_RELOAD 16'hFFFF
`define RST_MASK 4'h0
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 5
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define INTERVAL_PRESCALE 32'h00000010
`endif

// *** hw/system_timer_pkg.sv ***
// types of the system timer
package system_timer_pkg;
   typedef logic [3:0] irq_vec_t;
endpackage

// *** hw/tick_divider.sv ***
// prescaler producing a one-cycle enable pulse every div cycles
`timescale 1ns/1ps
module tick_divider #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // control
   input wire logic enable_in,
   input wire logic [WIDTH-1:0] div_in,
   // tick
   output logic tick_out
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic tick;
   } div_state_t;
   div_state_t state_q;
   div_state_t state_d;

   // a one-bit counter cannot tell the first cycle from the last
   if (WIDTH < 2) begin : g_width_check
      $error("tick_divider width too small");
   end

   always_comb begin
      state_d = state_q;
      state_d.tick = 1'b0;
      if (!enable_in) begin
         state_d.count = '0;
      end else if (state_q.count + WIDTH'(1) >= div_in) begin
         state_d.count = '0;
         state_d.tick = 1'b1;
      end else begin
         state_d.count = state_q.count + WIDTH'(1);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign tick_out = state_q.tick;
endmodule // tick_divider

// *** verification/system_timer_irq_disable_tb.sv ***
// self-checking testbench of the system timer interrupt masking
`timescale 1ns/1ps
module system_timer_irq_disable_tb;
   logic mclk_in = 1'h0;
   logic resetn_in = 1'h0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'h0;
   logic rd_in = 1'h0;
   logic [31:0] rdata_out;
   logic timer_irq_out;
   logic watchdog_reset_out;
   int error_cnt = 0;
   int comparisons = 0;
   always #2.5 mclk_in = ~mclk_in;
   // short divisors keep the second and the tick within a brief run
   system_timer #(.SECOND_DIV(10), .INTERVAL_DIV(2)) system_timer_i (.mclk_in, .resetn_in,
      .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .timer_irq_out, .watchdog_reset_out);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'h1;
      @(posedge mclk_in);
      wr_in <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'h1;
      @(posedge mclk_in);
      rd_in <= 1'h0;
      #1 d = rdata_out;
   endtask
   task automatic wait_irq(input logic exp);
      int n = 0;
      while (timer_irq_out !== exp && n < 4000) begin
         @(posedge mclk_in);
         #1 n++;
      end
      chk("irq", {31'h0, timer_irq_out}, {31'h0, exp});
      if (timer_irq_out !== exp) end_sim;
   endtask
   task automatic irq_drop(input logic [31:0] bits);
      wr(8'h18, bits);
      @(posedge mclk_in);
      #1 chk("irq off", {31'h0, timer_irq_out}, 32'h0);
   endtask
   task automatic t_clear_bits;
      logic [31:0] d;
      logic [3:0] m;
      m = 4'hF;
      rd(8'hFC, d);
      rd(8'h1C, d);
      chk("mask reset", d, 32'h0);
      wr(8'h14, 32'hF);
      wr(8'h18, 32'hFFFF_FFF0);
      rd(8'h1C, d);
      chk("mask zeros", d, 32'hF);
      for (int k = 0; k < 4; k++) begin
         wr(8'h18, 32'h1 << k);
         m[k] = 1'h0;
         rd(8'h1C, d);
         chk("mask clear", d, {28'h0, m});
      end
   endtask
   task automatic t_seconds;
      logic [31:0] d;
      wr(8'h14, 32'h4);
      wait_irq(1'h1);
      rd(8'h10, d);
      chk("status", d & 32'h4, 32'h4);
      irq_drop(32'h4);
   endtask
   task automatic t_interval;
      wr(8'h04, 32'h3);
      wr(8'h14, 32'h1);
      wait_irq(1'h1);
      irq_drop(32'h1);
   endtask
   task automatic t_alarm;
      logic [31:0] d;
      rd(8'h20, d);
      wr(8'h0C, d + 32'h3);
      wr(8'h14, 32'h8);
      wait_irq(1'h1);
      rd(8'h10, d);
      chk("alarm status", d & 32'h8, 32'h8);
      irq_drop(32'h8);
   endtask
   task automatic t_watchdog;
      int n = 0;
      wr(8'h14, 32'h2);
      wr(8'h08, 32'h0001_0004);
      wr(8'h00, 32'hA5A5_0001);
      while (watchdog_reset_out !== 1'h1 && n < 4000) begin
         @(posedge mclk_in);
         #1 n++;
      end
      chk("watchdog reset", {31'h0, watchdog_reset_out}, 32'h1);
      if (watchdog_reset_out !== 1'h1) end_sim;
      wait_irq(1'h1);
      wr(8'h08, 32'h0);
      irq_drop(32'hF);
   endtask
   initial begin
      repeat (5) @(posedge mclk_in);
      resetn_in <= 1'h1;
      t_clear_bits;
      t_seconds;
      t_interval;
      t_alarm;
      t_watchdog;
      end_sim;
   end
endmodule // system_timer_irq_disable_tb

// *** verification/system_timer_monitor.sv ***
// checker of the system timer register port and interrupt output
`timescale 1ns/1ps
module system_timer_monitor #(
   parameter int SECOND_DIV = 10,
   parameter int INTERVAL_DIV = 2
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // timer events
   input wire logic timer_irq_out,
   input wire logic watchdog_reset_out
);
   logic [3:0] mask_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // shadow of the mask, kept from the set and clear writes alone
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) mask_q <= 4'h0;
      else if (wr_in && addr_in == 8'h14) mask_q <= mask_q | wdata_in[3:0];
      else if (wr_in && addr_in == 8'h18) mask_q <= mask_q & ~wdata_in[3:0];
   end
   a_mask_readback: assert property (rd_in && addr_in == 8'h1C
      |=> rdata_out == {28'h0, $past(mask_q)}) else $error("mask readback wrong");
   a_irq_none_enabled: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0
      |-> !timer_irq_out) else $error("irq with empty mask");
   a_clear_all_quiet: assert property (wr_in && addr_in == 8'h18 && wdata_in[3:0] == 4'hF
      ##1 !(wr_in && addr_in == 8'h14) |-> ##1 !timer_irq_out) else $error("irq after clear");
   a_wd_pulse_short: assert property (watchdog_reset_out |=> !watchdog_reset_out)
      else $error("watchdog pulse too long");
   a_unmapped_zero: assert property (rd_in && addr_in == 8'hFC |=> rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_idle_rdata_zero: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data without read");
   a_status_upper_zero: assert property (rd_in && addr_in == 8'h10
      |=> rdata_out[31:4] == 28'h0) else $error("status upper bits set");
   a_clear_no_unmask: assert property (wr_in && addr_in == 8'h18
      ##1 !wr_in ##1 rd_in && addr_in == 8'h1C
      |=> (rdata_out[3:0] & $past(wdata_in[3:0], 3)) == 4'h0) else $error("clear did not mask");
endmodule // system_timer_monitor
bind system_timer system_timer_monitor #(.SECOND_DIV(SECOND_DIV), .INTERVAL_DIV(INTERVAL_DIV))
   system_timer_monitor_i (.mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .timer_irq_out, .watchdog_reset_out);
